/* File: cld_detector.v */
/*
  cold load pick-up and inrush detector with an avalon-mm register slave.
  assumes phase currents and harmonic ratios come from logic on i_clk,
  already settled, so they are read without synchronisers.
*/
// Chosen here: the address map and the Avalon-MM register port.
// Summary of operation
// RULE1 - all idle then pick-up within 80ms
// RULE2 - hold until max time or below pick-up
// RULE3 - detections exported as matrix selectable outputs
// RULE4 - inrush adds second harmonic ratio condition
// RULE5 - zero harmonic threshold makes inrush equal cold
// RULE6 - block at rise, keep after cycle if harmonic
// RULE7 - lingering between thresholds past 80ms disarms
// RULE8 - cold status start while active, trip timeout
// RULE9 - inrush status start while detected, trip timeout
// RULE10 - supervised current is maximum of three phases
// RULE11 - thresholds in nominal units, also primary amperes
// RULE12 - strobe-timed counters cleared on reset
`include "cld_map.vh"
`default_nettype none

module cld_detector #(
  parameter TICK_CYCLES = `CLD_CLK_HZ / 1000000 * `CLD_TICK_US
) (
  input wire i_clk,
  input wire i_rst_n,
  input wire i_ce,
  input wire [15:0] i_phase_current_a,
  input wire [15:0] i_phase_current_b,
  input wire [15:0] i_phase_current_c,
  input wire [7:0] i_harm_ratio_a,
  input wire [7:0] i_harm_ratio_b,
  input wire [7:0] i_harm_ratio_c,
  input wire [5:0] i_avs_address,
  input wire i_avs_read,
  input wire i_avs_write,
  input wire [31:0] i_avs_writedata,
  input wire [3:0] i_avs_byteenable,
  output reg [31:0] o_avs_readdata,
  output reg o_avs_waitrequest,
  output reg o_cold_load_start,
  output reg o_cold_load_trip,
  output reg o_inrush_start,
  output reg o_inrush_trip,
  output reg o_inrush_block
);

  // ***************************************************
  // constants
  // ***************************************************
  localparam [31:0] WIN_W = (`CLD_WIN_MS * 1000) / `CLD_TICK_US;
  localparam [31:0] CYCLE_W = (`CLD_CYCLE_MS * 1000) / `CLD_TICK_US;
  localparam [31:0] TICK_W = TICK_CYCLES - 1;
  localparam [6:0] WIN_TICKS = WIN_W[6:0];
  localparam [15:0] CYCLE_TICKS = CYCLE_W[15:0];
  localparam [14:0] TICK_LAST = TICK_W[14:0];

  localparam [2:0] S_WAIT = 3'h0;
  localparam [2:0] S_IDLE = 3'h1;
  localparam [2:0] S_TRANS = 3'h2;
  localparam [2:0] S_ACTIVE = 3'h3;
  localparam [2:0] S_TRIP = 3'h4;

  // ***************************************************
  // registers
  // ***************************************************
  reg enable_r;
  reg [15:0] idle_thr_r;
  reg [15:0] pickup_thr_r;
  reg [15:0] max_active_time_r;
  reg [7:0] harmonic_ratio_threshold_r;
  reg [15:0] scale_r;
  reg [15:0] max_phase_current_r;
  reg [2:0] harm_hit_r;
  reg [14:0] tick_cnt_r;
  reg tick_r;
  reg [6:0] win_cnt_r;
  reg [15:0] act_cnt_r;
  reg [2:0] state_r;
  reg [2:0] state_nxt;
  reg inr_latch_r;

  wire [15:0] max_ab = (i_phase_current_a > i_phase_current_b) ?
    i_phase_current_a : i_phase_current_b;
  wire [15:0] max_abc = (max_ab > i_phase_current_c) ? max_ab : i_phase_current_c;
  wire [7:0] harm_in [0:2];
  assign harm_in[0] = i_harm_ratio_a;
  assign harm_in[1] = i_harm_ratio_b;
  assign harm_in[2] = i_harm_ratio_c;

  wire below_idle = max_phase_current_r < idle_thr_r;
  wire above_pickup = max_phase_current_r > pickup_thr_r;
  wire below_pickup = max_phase_current_r < pickup_thr_r;
  // a zero threshold turns the harmonic test into a constant pass
  wire harm_ok = (harmonic_ratio_threshold_r == 8'h00) | (|harm_hit_r); // see RULE5
  wire first_cycle = act_cnt_r < CYCLE_TICKS;
  wire [31:0] idle_pri = idle_thr_r * scale_r;
  wire [31:0] pickup_pri = pickup_thr_r * scale_r;

  // ***************************************************
  // measurement pipeline
  // ***************************************************
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      max_phase_current_r <= 16'h0000;
    end else if (i_ce) begin
      max_phase_current_r <= max_abc; // see RULE10
    end
  end

  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_harm
      always @(posedge i_clk) begin
        if (!i_rst_n) begin
          harm_hit_r[g] <= 1'b0;
        end else if (i_ce) begin
          harm_hit_r[g] <= harm_in[g] > harmonic_ratio_threshold_r; // see RULE4
        end
      end
    end
  endgenerate

  // ***************************************************
  // millisecond strobe
  // ***************************************************
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      tick_cnt_r <= 15'h0000;
      tick_r <= 1'b0;
    end else if (i_ce) begin
      tick_r <= tick_cnt_r == TICK_LAST; // see RULE12
      if (tick_cnt_r == TICK_LAST) begin
        tick_cnt_r <= 15'h0000;
      end else begin
        tick_cnt_r <= tick_cnt_r + 15'h0001;
      end
    end
  end

  // ***************************************************
  // detection state machine
  // ***************************************************
  always @* begin
    state_nxt = state_r;
    case (state_r)
      S_WAIT: begin
        if (below_idle) begin
          state_nxt = S_IDLE;
        end
      end
      S_IDLE: begin
        if (above_pickup) begin
          state_nxt = S_ACTIVE; // see RULE1
        end else if (!below_idle) begin
          state_nxt = S_TRANS;
        end
      end
      S_TRANS: begin
        if (above_pickup) begin
          state_nxt = S_ACTIVE; // see RULE1
        end else if (below_idle) begin
          state_nxt = S_IDLE;
        end else if (win_cnt_r >= WIN_TICKS) begin
          state_nxt = S_WAIT; // see RULE7
        end
      end
      S_ACTIVE: begin
        if (below_pickup) begin
          state_nxt = S_WAIT; // see RULE2
        end else if (act_cnt_r >= max_active_time_r) begin
          state_nxt = S_TRIP; // see RULE2
        end
      end
      S_TRIP: begin
        if (below_pickup) begin
          state_nxt = S_WAIT;
        end
      end
      default: begin
        state_nxt = S_WAIT;
      end
    endcase
    if (!enable_r) begin
      state_nxt = S_WAIT;
    end
  end

  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      state_r <= S_WAIT;
      win_cnt_r <= 7'h00;
      act_cnt_r <= 16'h0000;
      inr_latch_r <= 1'b0;
    end else if (i_ce) begin
      state_r <= state_nxt;
      // both timers restart whenever their state is entered afresh
      if (state_nxt != S_TRANS || state_r != S_TRANS) begin
        win_cnt_r <= 7'h00;
      end else if (tick_r) begin
        win_cnt_r <= win_cnt_r + 7'h01; // see RULE12
      end
      if (state_nxt != S_ACTIVE || state_r != S_ACTIVE) begin
        act_cnt_r <= 16'h0000;
      end else if (tick_r && act_cnt_r != 16'hffff) begin
        act_cnt_r <= act_cnt_r + 16'h0001; // see RULE12
      end
      // remembers whether inrush was present at the moment of timeout
      if (state_r == S_ACTIVE && state_nxt == S_TRIP) begin
        inr_latch_r <= harm_ok; // see RULE9
      end else if (state_nxt != S_TRIP) begin
        inr_latch_r <= 1'b0;
      end
    end
  end

  // ***************************************************
  // detection outputs
  // ***************************************************
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_cold_load_start <= 1'b0;
      o_cold_load_trip <= 1'b0;
      o_inrush_start <= 1'b0;
      o_inrush_trip <= 1'b0;
      o_inrush_block <= 1'b0;
    end else if (i_ce) begin
      o_cold_load_start <= state_r == S_ACTIVE; // see RULE8 see RULE3
      o_cold_load_trip <= state_r == S_TRIP; // see RULE8 see RULE3
      o_inrush_start <= state_r == S_ACTIVE && harm_ok; // see RULE4 see RULE9
      o_inrush_trip <= state_r == S_TRIP && inr_latch_r; // see RULE9 see RULE3
      // the harmonic figure is unreliable until a full cycle has been seen
      o_inrush_block <= state_r == S_ACTIVE && (first_cycle || harm_ok); // see RULE6
    end
  end

  // ***************************************************
  // avalon-mm slave
  // ***************************************************
  // one wait cycle per access: request seen, then waitrequest low for a cycle
  wire req = i_avs_read | i_avs_write;
  wire wr_go = i_avs_write & ~o_avs_waitrequest;

  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_avs_waitrequest <= 1'b1;
      o_avs_readdata <= 32'h00000000;
    end else if (i_ce) begin
      o_avs_waitrequest <= ~(req & o_avs_waitrequest);
      if (i_avs_read && o_avs_waitrequest) begin
        case (i_avs_address)
          `CLD_OFS_CTRL: o_avs_readdata <= {31'h00000000, enable_r};
          `CLD_OFS_IDLE: o_avs_readdata <= {16'h0000, idle_thr_r}; // see RULE11
          `CLD_OFS_PICKUP: o_avs_readdata <= {16'h0000, pickup_thr_r};
          `CLD_OFS_MAX_ACTIVE_TIME: o_avs_readdata <= {16'h0000, max_active_time_r};
          `CLD_OFS_HARM: o_avs_readdata <= {24'h000000, harmonic_ratio_threshold_r};
          `CLD_OFS_STATUS: o_avs_readdata <= {27'h0000000, o_inrush_block,
            o_inrush_trip, o_inrush_start, o_cold_load_trip, o_cold_load_start};
          `CLD_OFS_MAXCUR: o_avs_readdata <= {16'h0000, max_phase_current_r};
          `CLD_OFS_SCALE: o_avs_readdata <= {16'h0000, scale_r};
          `CLD_OFS_IDLE_PRI: o_avs_readdata <= {8'h00, idle_pri[31:8]}; // see RULE11
          `CLD_OFS_PICKUP_PRI: o_avs_readdata <= {8'h00, pickup_pri[31:8]}; // see RULE11
          default: o_avs_readdata <= 32'h00000000;
        endcase
      end
    end
  end

  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      enable_r <= `CLD_RST_CTRL;
      idle_thr_r <= `CLD_RST_IDLE;
      pickup_thr_r <= `CLD_RST_PICKUP;
      max_active_time_r <= `CLD_RST_MAX_ACTIVE_TIME;
      harmonic_ratio_threshold_r <= `CLD_RST_HARM;
      scale_r <= `CLD_RST_SCALE;
    end else if (i_ce && wr_go) begin
      case (i_avs_address)
        `CLD_OFS_CTRL: begin
          if (i_avs_byteenable[0]) enable_r <= i_avs_writedata[`CLD_CTRL_EN];
        end
        `CLD_OFS_IDLE: begin
          if (i_avs_byteenable[0]) idle_thr_r[7:0] <= i_avs_writedata[7:0];
          if (i_avs_byteenable[1]) idle_thr_r[15:8] <= i_avs_writedata[15:8];
        end
        `CLD_OFS_PICKUP: begin
          if (i_avs_byteenable[0]) pickup_thr_r[7:0] <= i_avs_writedata[7:0];
          if (i_avs_byteenable[1]) pickup_thr_r[15:8] <= i_avs_writedata[15:8];
        end
        `CLD_OFS_MAX_ACTIVE_TIME: begin
          if (i_avs_byteenable[0]) max_active_time_r[7:0] <= i_avs_writedata[7:0];
          if (i_avs_byteenable[1]) max_active_time_r[15:8] <= i_avs_writedata[15:8];
        end
        `CLD_OFS_HARM: begin
          if (i_avs_byteenable[0]) harmonic_ratio_threshold_r <= i_avs_writedata[7:0];
        end
        `CLD_OFS_SCALE: begin
          if (i_avs_byteenable[0]) scale_r[7:0] <= i_avs_writedata[7:0];
          if (i_avs_byteenable[1]) scale_r[15:8] <= i_avs_writedata[15:8];
        end
        default: begin
          enable_r <= enable_r;
        end
      endcase
    end
  end

endmodule // cld_detector

`default_nettype wire

/* File: cld_detector_test.sv */
/*
  self-checking bench of the cold load / inrush detector.
  assumes cld_meas feeds the phases; an avalon master task reaches registers.
*/
`default_nettype none
module cld_detector_test;
  timeunit 1ns;
  timeprecision 1ns;
  // ************
  // stimulus and wiring
  // ************
  localparam int T = 4;
  logic i_clk = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  logic [15:0] pk = 16'h0010;
  logic [7:0] hr = 8'h00;
  logic [1:0] sel = 2'd0;
  logic [5:0] av_a = 6'h00;
  logic av_r = 1'b0;
  logic av_w = 1'b0;
  logic [31:0] av_d = 32'h0;
  logic [31:0] rdata, got;
  logic [15:0] ca, cb, cc;
  logic [7:0] ha, hb, hc;
  logic wreq, st, tr, ist, itr, blk;
  integer seed = 32'h0a2b;
  int n_fail = 0;
  int comparisons = 0;
  int cyc = 0;
  int t0, i;
  logic [7:0] hv [4] = '{8'h00, 8'h1e, 8'h14, 8'h00};
  logic [7:0] tv [4] = '{8'h14, 8'h14, 8'h14, 8'h00};
  logic [31:0] rv [10] = '{32'h1, 32'h33, 32'h133, 32'h3e8, 32'h14, 32'h0, 32'h10, 32'h64,
    32'h13, 32'h77};
  always #20 i_clk = ~i_clk;
  always @(posedge i_clk) cyc <= cyc + 1;
  cld_meas u_meas (.i_clk(i_clk), .i_peak(pk), .i_harm(hr), .i_sel(sel), .o_cur_a(ca),
    .o_cur_b(cb), .o_cur_c(cc), .o_harm_a(ha), .o_harm_b(hb), .o_harm_c(hc));
  cld_detector #(.TICK_CYCLES(T)) dut (.i_clk(i_clk), .i_rst_n(rst_n), .i_ce(ce),
    .i_phase_current_a(ca), .i_phase_current_b(cb), .i_phase_current_c(cc),
    .i_harm_ratio_a(ha), .i_harm_ratio_b(hb), .i_harm_ratio_c(hc), .i_avs_address(av_a),
    .i_avs_read(av_r), .i_avs_write(av_w), .i_avs_writedata(av_d), .i_avs_byteenable(4'hf),
    .o_avs_readdata(rdata), .o_avs_waitrequest(wreq), .o_cold_load_start(st),
    .o_cold_load_trip(tr), .o_inrush_start(ist), .o_inrush_trip(itr), .o_inrush_block(blk));
  // ************
  // tasks
  // ************
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wt(input int k);
    repeat (k) @(posedge i_clk);
  endtask
  // one extra edge after release so back-to-back calls never touch a strobe twice
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    av_a <= a;
    av_d <= d;
    av_w <= w;
    av_r <= !w;
    wt(1);
    while (wreq) wt(1);
    got = rdata;
    av_w <= 1'b0;
    av_r <= 1'b0;
    wt(1);
  endtask
  task automatic lin(input int k, input logic e);
    pk <= 16'h0010;
    wt(6);
    if (k > 0) begin
      pk <= 16'h0080;
      wt(k);
    end
    pk <= 16'h0200;
    wt(6);
    chk("window", e, st);
  endtask
  task automatic shot(input logic [7:0] h, input logic [7:0] th);
    logic ei;
    int n;
    ei = (h > th) || (th == 8'h00);
    bus(1'b1, 6'h10, {24'h0, th});
    pk <= 16'h0010;
    wt(6);
    pk <= 16'h0140 + 16'($random(seed) & 32'h0fff);
    sel <= 2'($unsigned($random(seed)) % 3);
    hr <= h;
    t0 = cyc;
    wt(6);
    chk("start", 32'h1, st);
    chk("block", 32'h1, blk);
    chk("inrush", ei, ist);
    bus(1'b0, 6'h18, 32'h0);
    chk("max current", pk, got);
    wt(23 * T);
    chk("late block", ei, blk);
    n = 0;
    while (tr !== 1'b1 && n < 40 * T) begin
      wt(1);
      n++;
    end
    chk("trip time", 32'h1, (cyc - t0 >= 29 * T) && (cyc - t0 <= 31 * T + 8));
    chk("start at trip", 32'h0, st);
    chk("inrush trip", ei, itr);
    bus(1'b0, 6'h14, 32'h0);
    chk("status", {28'h0, ei, 3'b010}, got);
    pk <= 16'h0010;
    wt(6);
    chk("trip release", 32'h0, tr);
  endtask
  task automatic give_verdict;
    if (n_fail == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // ************
  // sequence
  // ************
  initial begin
    wt(8);
    rst_n <= 1'b1;
    wt(2);
    for (i = 0; i < 10; i++) begin
      bus(1'b0, 6'(i * 4), 32'h0);
      chk("reset value", rv[i], got);
    end
    bus(1'b0, 6'h28, 32'h0);
    chk("unmapped", 32'h0, got);
    bus(1'b1, 6'h14, 32'h1f);
    bus(1'b0, 6'h14, 32'h0);
    chk("status ro", 32'h0, got);
    bus(1'b1, 6'h0c, 32'd30);
    for (i = 0; i < 4; i++) shot(hv[i], tv[i]);
    lin(70 * T, 1'b1);
    pk <= 16'h0100;
    wt(6);
    chk("drop", 32'h0, {st, tr});
    lin(84 * T, 1'b0);
    bus(1'b1, 6'h00, 32'h0);
    lin(0, 1'b0);
    bus(1'b1, 6'h00, 32'h1);
    lin(0, 1'b1);
    // with the clock enable low the drop below pick-up must not be seen yet
    ce <= 1'b0;
    pk <= 16'h0010;
    wt(8);
    chk("frozen start", 32'h1, st);
    ce <= 1'b1;
    wt(6);
    chk("thawed start", 32'h0, st);
    give_verdict;
  end
  initial begin
    wt(20000);
    n_fail++;
    give_verdict;
  end
endmodule // cld_detector_test
`default_nettype wire

/* File: cld_map.vh */
/*
  register offsets, field positions, reset values and timing figures of the
  cold load / inrush detector.
  assumes a 25 MHz system clock and a 32-bit avalon-mm slave port.
*/
`ifndef CLD_MAP_VH
`define CLD_MAP_VH

// ***************************************************
// register byte offsets
// ***************************************************
`define CLD_OFS_CTRL 6'h00
`define CLD_OFS_IDLE 6'h04
`define CLD_OFS_PICKUP 6'h08
`define CLD_OFS_MAX_ACTIVE_TIME 6'h0c
`define CLD_OFS_HARM 6'h10
`define CLD_OFS_STATUS 6'h14
`define CLD_OFS_MAXCUR 6'h18
`define CLD_OFS_SCALE 6'h1c
`define CLD_OFS_IDLE_PRI 6'h20
`define CLD_OFS_PICKUP_PRI 6'h24

// ***************************************************
// field positions
// ***************************************************
`define CLD_CTRL_EN 0
`define CLD_ST_COLD_START 0
`define CLD_ST_COLD_TRIP 1
`define CLD_ST_INR_START 2
`define CLD_ST_INR_TRIP 3
`define CLD_ST_INR_BLOCK 4

// ***************************************************
// reset values
// ***************************************************
`define CLD_RST_CTRL 1'h1
`define CLD_RST_IDLE 16'h0033
`define CLD_RST_PICKUP 16'h0133
`define CLD_RST_MAX_ACTIVE_TIME 16'h03e8
`define CLD_RST_HARM 8'h14
`define CLD_RST_SCALE 16'h0064

// ***************************************************
// timing
// ***************************************************
`define CLD_CLK_HZ 25000000
`define CLD_TICK_US 1000
`define CLD_WIN_MS 80
`define CLD_CYCLE_MS 20

`endif

/* File: cld_meas.sv */
/*
  measurement front end: phase magnitudes and harmonic ratios.
  assumes the bench picks the level and the phase that carries it.
*/
`default_nettype none
module cld_meas (
  input wire logic i_clk,
  input wire logic [15:0] i_peak,
  input wire logic [7:0] i_harm,
  input wire logic [1:0] i_sel,
  output var logic [15:0] o_cur_a = 16'h0010,
  output var logic [15:0] o_cur_b = 16'h0010,
  output var logic [15:0] o_cur_c = 16'h0010,
  output var logic [7:0] o_harm_a = 8'h00,
  output var logic [7:0] o_harm_b = 8'h00,
  output var logic [7:0] o_harm_c = 8'h00
);
  timeunit 1ns;
  timeprecision 1ns;
  // unselected phases sit low so only one phase sets the maximum
  always @(posedge i_clk) begin
    o_cur_a <= (i_sel == 2'd0) ? i_peak : 16'h0010;
    o_cur_b <= (i_sel == 2'd1) ? i_peak : 16'h0010;
    o_cur_c <= (i_sel == 2'd2) ? i_peak : 16'h0010;
    o_harm_a <= (i_sel == 2'd0) ? i_harm : 8'h00;
    o_harm_b <= (i_sel == 2'd1) ? i_harm : 8'h00;
    o_harm_c <= (i_sel == 2'd2) ? i_harm : 8'h00;
  end
endmodule // cld_meas
`default_nettype wire

/* File: cld_props.sv */
/*
  port checker of the cold load / inrush detector.
  assumes idle and pick-up thresholds stay at their reset values.
*/
`include "cld_map.vh"
`default_nettype none
module cld_props #(
  parameter TICK_CYCLES = 25000
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire logic [15:0] i_phase_current_a,
  input wire logic [15:0] i_phase_current_b,
  input wire logic [15:0] i_phase_current_c,
  input wire logic o_cold_load_start,
  input wire logic o_cold_load_trip,
  input wire logic o_inrush_start,
  input wire logic o_inrush_trip,
  input wire logic o_inrush_block
);
  timeunit 1ns;
  timeprecision 1ns;
  // ************
  // helpers
  // ************
  // slack covers the partial first tick and the pipeline
  localparam int WIN = 81 * TICK_CYCLES + 8;
  localparam int BLK = 21 * TICK_CYCLES + 6;
  localparam [15:0] PICK = `CLD_RST_PICKUP;
  wire [15:0] mab = (i_phase_current_a > i_phase_current_b) ?
    i_phase_current_a : i_phase_current_b;
  wire [15:0] mx = (mab > i_phase_current_c) ? mab : i_phase_current_c;
  logic [31:0] idle_age_r;
  logic [31:0] act_age_r;
  logic [4:0] hi_r;
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      idle_age_r <= 32'h0;
      act_age_r <= 32'h0;
      hi_r <= 5'h0;
    end else if (i_ce) begin
      idle_age_r <= (mx < `CLD_RST_IDLE) ? 32'h0 : idle_age_r + 32'h1;
      act_age_r <= o_cold_load_start ? act_age_r + 32'h1 : 32'h0;
      hi_r <= {hi_r[3:0], mx > PICK};
    end
  end
  // ************
  // properties
  // ************
  default clocking @(posedge i_clk); endclocking
  // a frozen detector stretches every latency, so attempts across a freeze are dropped
  default disable iff (!i_rst_n || !i_ce);
  chk_rise_block: assert property ($rose(o_cold_load_start) |-> o_inrush_block)
    else $error("no block at rise");
  chk_inr_cold: assert property (o_inrush_start |-> o_cold_load_start)
    else $error("inrush without cold load");
  chk_rise_window: assert property ($rose(o_cold_load_start) |-> idle_age_r <= WIN)
    else $error("rise outside window");
  chk_rise_level: assert property ($rose(o_cold_load_start) |-> hi_r != 5'h0)
    else $error("rise without pick-up");
  chk_drop_release:
    assert property ((mx < PICK) [*4] |=> !o_cold_load_start && !o_cold_load_trip)
    else $error("no release below pick-up");
  chk_block_late: assert property (act_age_r > BLK |-> o_inrush_block == o_inrush_start)
    else $error("late block mismatch");
  chk_inr_trip: assert property (o_inrush_trip |-> o_cold_load_trip)
    else $error("inrush trip alone");
  chk_trip_excl: assert property (!(o_cold_load_start && o_cold_load_trip))
    else $error("start and trip together");
  cov_inr_trip: cover property (o_inrush_trip);
  cov_block_fall: cover property ($fell(o_inrush_block) && o_cold_load_start);
  cov_drop: cover property ($fell(o_cold_load_start) && !o_cold_load_trip);
endmodule // cld_props
bind cld_detector cld_props #(.TICK_CYCLES(TICK_CYCLES)) u_props (
  .i_clk(i_clk), .i_rst_n(i_rst_n), .i_ce(i_ce), .i_phase_current_a(i_phase_current_a),
  .i_phase_current_b(i_phase_current_b), .i_phase_current_c(i_phase_current_c),
  .o_cold_load_start(o_cold_load_start), .o_cold_load_trip(o_cold_load_trip),
  .o_inrush_start(o_inrush_start), .o_inrush_trip(o_inrush_trip),
  .o_inrush_block(o_inrush_block)
);
`default_nettype wire
